// ### include/vap_defines.vh
// Purpose: constants for the voltage rms / active power slice
// Assumes: register byte address = 4 * register index
// Notes:   thresholds are in active power lsb before calibration
`ifndef VAP_DEFINES_VH
`define VAP_DEFINES_VH
// register indices
`define VAP_IDX_MODE_CONTROL_TWO     8'h0C
`define VAP_IDX_NOLOAD_MODE    8'h0E
`define VAP_IDX_ACCUMULATION_MODE   8'h0F
`define VAP_IDX_IRQ_EN    8'hD9
`define VAP_IDX_IRQ_ST    8'hDC
`define VAP_IDX_VRMS      8'h40
`define VAP_IDX_VRMS_OS   8'h41
`define VAP_IDX_PGAIN     8'h42
`define VAP_IDX_POFFS     8'h43
`define VAP_IDX_APOWER    8'h44
// field positions
`define VAP_MODE_CONTROL_TWO_ZERO_CROSS_RMS_UPDATE   0
`define VAP_ACC_SIGNSEL   3
`define VAP_IRQ_SIGN      0
`define VAP_IRQ_NOLOAD    1
// reset values
`define VAP_RST_MODE      8'h00
`define VAP_RST_CAL12     12'h000
`define VAP_RST_CAL16     16'h0000
// update divider: master clock / 5
`define VAP_DIV           3'h5
// rms offset weight 64 = shift by 6
`define VAP_RMSOS_SHIFT   6
// gain 1 + g/4096
`define VAP_GAIN_SHIFT    12
// 256 offset lsb per sample lsb
`define VAP_POFF_SHIFT    8
// no-load thresholds 0.015%, 0.0075%, 0.0037% of 0xCCCCD
`define VAP_NL_TH1        24'h00007E
`define VAP_NL_TH2        24'h00003F
`define VAP_NL_TH3        24'h00001F
// rms lowpass: 2 Hz at 4.096 MHz / 5 -> alpha about 2^-16
`define VAP_RMS_LPF_SHIFT 16
`define VAP_PWR_LPF_SHIFT 8
// product scale to active power lsb (full scale dc about 0xCCCCD)
`define VAP_PWR_SCALE     22
`define VAP_RMS_MAX       24'hFFFFFF
// axi responses
`define VAP_RESP_OKAY     2'h0
`define VAP_RESP_SLVERR   2'h2
`endif

// ### logic/vap_dsp.v
// Purpose: voltage rms and active power slice with calibration and flags
// Assumes: samples come from logic on clk and are read at each update
// Notes:   registers on axi4-lite, byte address = 4 * index
// What this block does
// RQ1: voltage rms is computed from the voltage samples and kept as unsigned 24 bits.
// RQ2: the rms result refreshes at clock/5 unless zero-crossing updating is chosen.
// RQ3: with the zero-cross bit set, the rms register updates only on voltage zero crossings.
// RQ4: a full-scale sine gives an rms reading near 0x1CF68C.
// RQ5: a 12-bit signed rms offset register is writable by software.
// RQ6: corrected rms equals raw rms plus 64 times the signed offset.
// RQ7: instantaneous power is v times i and active power is its lowpass dc part.
// RQ8: active power is scaled by 1 + gain/4096 with a signed 12-bit gain.
// RQ9: a signed 16-bit offset is added, 256 offset lsb per sample lsb.
// RQ10: the sign flag sets on a + to - change, or - to + when sign select is set.
// RQ11: an enabled sign flag drives the interrupt until software clears it.
// RQ12: below the no-load threshold energy is gated and the no-load flag sets.
// RQ13: an enabled no-load flag drives the interrupt until software clears it.
// RQ14: the 2-bit no-load field picks off, 0.015%, 0.0075% or 0.0037% of full scale.
// RQ15: the rms averaging lowpass has a 2 Hz corner at a 4.096 MHz clock.
// RQ16: the corrected rms clamps at zero instead of wrapping.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "vap_defines.vh"

module vap_dsp
#(
   parameter SW        = 24,
   parameter AW        = 12,
   parameter RMS_SHIFT = `VAP_RMS_LPF_SHIFT,
   parameter PWR_SHIFT = `VAP_PWR_LPF_SHIFT
)
(
   input  wire                 clk,
   input  wire                 reset,
   input  wire signed [SW-1:0] v_sample,
   input  wire signed [SW-1:0] i_sample,
   input  wire [AW-1:0]        s_axi_awaddr,
   input  wire                 s_axi_awvalid,
   output reg                  s_axi_awready,
   input  wire [31:0]          s_axi_wdata,
   input  wire [3:0]           s_axi_wstrb,
   input  wire                 s_axi_wvalid,
   output reg                  s_axi_wready,
   output reg  [1:0]           s_axi_bresp,
   output reg                  s_axi_bvalid,
   input  wire                 s_axi_bready,
   input  wire [AW-1:0]        s_axi_araddr,
   input  wire                 s_axi_arvalid,
   output reg                  s_axi_arready,
   output reg  [31:0]          s_axi_rdata,
   output reg  [1:0]           s_axi_rresp,
   output reg                  s_axi_rvalid,
   input  wire                 s_axi_rready,
   output reg  signed [31:0]   active_power_q,
   output reg                  update_tick_q,
   output reg                  noload_gate_q,
   output reg                  irq_q
);

   // integer square root, restoring method
   function [23:0] isqrt;
      input [47:0] x;
      reg   [47:0] rem;
      reg   [25:0] trial;
      reg   [23:0] root;
      integer      k;
      begin
         rem  = 48'h0;
         root = 24'h0;
         trial = 26'h0;
         for (k = 23; k >= 0; k = k - 1)
         begin
            rem   = {rem[45:0], x[2*k+1 -: 2]};
            trial = {root, 2'b01};
            if (rem >= {22'h0, trial})
            begin
               rem  = rem - {22'h0, trial};
               root = {root[22:0], 1'b1};
            end
            else
               root = {root[22:0], 1'b0};
         end
         isqrt = root;
      end
   endfunction

   // byte-strobe merge for register writes
   function [31:0] wmerge;
      input [31:0] old;
      input [31:0] data;
      input [3:0]  strb;
      integer      b;
      begin
         wmerge = old;
         for (b = 0; b < 4; b = b + 1)
            if (strb[b])
               wmerge[8*b +: 8] = data[8*b +: 8];
      end
   endfunction

   reg  [7:0]          mode_control_two_q;
   reg  [7:0]          noload_mode_q;
   reg  [7:0]          accumulation_mode_q;
   reg  [7:0]          irq_en_q;
   reg  [7:0]          irq_st_q;
   reg  [11:0]         vrms_os_q;
   reg  [11:0]         pgain_q;
   reg  [15:0]         poffs_q;
   reg  [23:0]         vrms_q;

   // update rate divider
   reg  [2:0]          div_q;
   wire                tick = (div_q == `VAP_DIV - 3'h1);
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         div_q         <= 3'h0;
         update_tick_q <= 1'b0;
      end
      else
      begin
         // RQ2 clock/5 update
         div_q         <= tick ? 3'h0 : div_q + 3'h1;
         update_tick_q <= tick;
      end
   end

   // rms path: square, average, root
   reg  [47:0]              vsq_q;
   reg  [47+RMS_SHIFT:0]    racc_q;
   reg  [23:0]              vrms_raw_q;
   reg                      vsign_q;
   reg                      zx_q;
   reg                      rms_stage_q;
   wire signed [47:0]       vsq_s   = v_sample * v_sample;
   wire [47:0]              rmean   = racc_q[47+RMS_SHIFT:RMS_SHIFT];
   wire signed [26:0]       os_term = {{15{vrms_os_q[11]}}, vrms_os_q} <<< `VAP_RMSOS_SHIFT;
   wire signed [26:0]       vcorr   = $signed({3'b000, vrms_raw_q}) + os_term;
   reg  [23:0]              vcorr_cl;

   always @*
   begin
      // RQ16 clamp not wrap
      if (vcorr[26])
         vcorr_cl = 24'h0;
      else if (vcorr[25:24] != 2'b00)
         vcorr_cl = `VAP_RMS_MAX;
      else
         vcorr_cl = vcorr[23:0];
   end

   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         vsq_q       <= 48'h0;
         racc_q      <= {(48+RMS_SHIFT){1'b0}};
         vrms_raw_q  <= 24'h0;
         vsign_q     <= 1'b0;
         zx_q        <= 1'b0;
         rms_stage_q <= 1'b0;
         vrms_q      <= 24'h0;
      end
      else
      begin
         rms_stage_q <= tick;
         if (tick)
         begin
            // RQ1 square of voltage sample
            vsq_q   <= vsq_s;
            // RQ15 averaging lowpass, alpha 2^-RMS_SHIFT
            racc_q  <= racc_q + {{RMS_SHIFT{1'b0}}, vsq_q} - {{RMS_SHIFT{1'b0}}, rmean};
            vsign_q <= v_sample[SW-1];
            zx_q    <= (v_sample[SW-1] != vsign_q);
         end
         if (rms_stage_q)
         begin
            // RQ4 root of mean square in sample lsb
            vrms_raw_q <= isqrt(rmean);
            // RQ3 zero-cross gated update
            if (!mode_control_two_q[`VAP_MODE_CONTROL_TWO_ZERO_CROSS_RMS_UPDATE] || zx_q)
               // RQ6 offset times 64
               vrms_q <= vcorr_cl;
         end
      end
   end

   // active power path
   reg  signed [47:0]            prod_q;
   reg  signed [47+PWR_SHIFT:0]  pacc_q;
   reg  signed [31:0]            praw_q;
   reg                           pstage_q;
   reg                           psign_q;
   reg                           sign_set_q;
   reg                           nl_set_q;
   wire signed [47:0]            prod_s = v_sample * i_sample;
   wire signed [47:0]            pfilt  = pacc_q[47+PWR_SHIFT:PWR_SHIFT];
   wire signed [47:0]            pscl   = pfilt >>> `VAP_PWR_SCALE;
   wire signed [43:0]            gprod  = praw_q * $signed(pgain_q);
   // signed operand keeps the gain shift arithmetic for negative products
   wire signed [43:0]            gsum   = $signed({{12{praw_q[31]}}, praw_q})
                                          + (gprod >>> `VAP_GAIN_SHIFT);
   wire signed [43:0]            osum   = (gsum <<< `VAP_POFF_SHIFT)
                                          + {{28{poffs_q[15]}}, poffs_q};
   wire signed [43:0]            pcal   = osum >>> `VAP_POFF_SHIFT;
   wire [31:0]                   pmag   = praw_q[31] ? 32'h0 - praw_q : praw_q;
   reg  [23:0]                   nl_th;

   always @*
   begin
      // RQ14 threshold select
      case (noload_mode_q[1:0])
         2'b01:   nl_th = `VAP_NL_TH1;
         2'b10:   nl_th = `VAP_NL_TH2;
         2'b11:   nl_th = `VAP_NL_TH3;
         default: nl_th = 24'h0;
      endcase
   end

   wire nl_now  = (noload_mode_q[1:0] != 2'b00) && (pmag < {8'h0, nl_th});
   wire ps_new  = pcal[43];
   // RQ10 edge direction chosen by sign select
   wire sign_ev = accumulation_mode_q[`VAP_ACC_SIGNSEL] ? (psign_q && !ps_new)
                                              : (!psign_q && ps_new);

   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         prod_q         <= 48'sh0;
         pacc_q         <= {(48+PWR_SHIFT){1'b0}};
         praw_q         <= 32'sh0;
         pstage_q       <= 1'b0;
         psign_q        <= 1'b0;
         sign_set_q     <= 1'b0;
         nl_set_q       <= 1'b0;
         active_power_q <= 32'sh0;
         noload_gate_q  <= 1'b0;
      end
      else
      begin
         pstage_q   <= tick;
         sign_set_q <= 1'b0;
         nl_set_q   <= 1'b0;
         if (tick)
         begin
            // RQ7 multiply then lowpass dc
            prod_q <= prod_s;
            pacc_q <= pacc_q + {{PWR_SHIFT{prod_q[47]}}, prod_q}
                             - {{PWR_SHIFT{pfilt[47]}}, pfilt};
            praw_q <= pscl[31:0];
         end
         if (pstage_q)
         begin
            // RQ8 RQ9 gain then offset
            active_power_q <= pcal[31:0];
            psign_q        <= ps_new;
            sign_set_q     <= sign_ev;
            // RQ12 gate energy below threshold
            noload_gate_q  <= nl_now;
            nl_set_q       <= nl_now;
         end
      end
   end

   // axi4-lite slave
   reg  [AW-1:0] awaddr_q;
   reg  [31:0]   wdata_q;
   reg  [3:0]    wstrb_q;
   reg           aw_got_q;
   reg           w_got_q;
   wire          aw_hs  = s_axi_awvalid && s_axi_awready;
   wire          w_hs   = s_axi_wvalid && s_axi_wready;
   wire [AW-1:0] wa     = aw_got_q ? awaddr_q : s_axi_awaddr;
   wire [31:0]   wd     = w_got_q ? wdata_q : s_axi_wdata;
   wire [3:0]    ws     = w_got_q ? wstrb_q : s_axi_wstrb;
   wire          do_wr  = (aw_got_q || aw_hs) && (w_got_q || w_hs) && !s_axi_bvalid;
   wire [7:0]    widx   = wa[9:2];
   wire          w_map  = (wa[AW-1:10] == 0) && (wa[1:0] == 2'b00);
   wire [7:0]    ridx   = s_axi_araddr[9:2];
   wire          r_map  = (s_axi_araddr[AW-1:10] == 0) && (s_axi_araddr[1:0] == 2'b00);
   wire          wr_st  = do_wr && w_map && (widx == `VAP_IDX_IRQ_ST);
   wire [7:0]    st_clr = (wr_st && ws[0]) ? wd[7:0] : 8'h0;
   wire [31:0]   m_os   = wmerge({20'h0, vrms_os_q}, wd, ws);
   wire [31:0]   m_gain = wmerge({20'h0, pgain_q}, wd, ws);
   wire [31:0]   m_poff = wmerge({16'h0, poffs_q}, wd, ws);
   reg  [31:0]   rd_val;
   reg           rd_ok;

   always @*
   begin
      rd_ok  = r_map;
      rd_val = 32'h0;
      case (ridx)
         `VAP_IDX_MODE_CONTROL_TWO:   rd_val = {24'h0, mode_control_two_q};
         `VAP_IDX_NOLOAD_MODE:  rd_val = {24'h0, noload_mode_q};
         `VAP_IDX_ACCUMULATION_MODE: rd_val = {24'h0, accumulation_mode_q};
         `VAP_IDX_IRQ_EN:  rd_val = {24'h0, irq_en_q};
         `VAP_IDX_IRQ_ST:  rd_val = {24'h0, irq_st_q};
         `VAP_IDX_VRMS:    rd_val = {8'h0, vrms_q};
         `VAP_IDX_VRMS_OS: rd_val = {20'h0, vrms_os_q};
         `VAP_IDX_PGAIN:   rd_val = {20'h0, pgain_q};
         `VAP_IDX_POFFS:   rd_val = {16'h0, poffs_q};
         `VAP_IDX_APOWER:  rd_val = active_power_q;
         default:          rd_ok  = 1'b0;
      endcase
   end

   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `VAP_RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `VAP_RESP_OKAY;
         awaddr_q      <= {AW{1'b0}};
         wdata_q       <= 32'h0;
         wstrb_q       <= 4'h0;
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         mode_control_two_q       <= `VAP_RST_MODE;
         noload_mode_q      <= `VAP_RST_MODE;
         accumulation_mode_q     <= `VAP_RST_MODE;
         irq_en_q      <= `VAP_RST_MODE;
         irq_st_q      <= `VAP_RST_MODE;
         vrms_os_q     <= `VAP_RST_CAL12;
         pgain_q       <= `VAP_RST_CAL12;
         poffs_q       <= `VAP_RST_CAL16;
         irq_q         <= 1'b0;
      end
      else
      begin
         if (aw_hs)
         begin
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (w_hs)
         begin
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_wr)
         begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (w_map && widx != `VAP_IDX_VRMS && widx != `VAP_IDX_APOWER
                             && (widx == `VAP_IDX_MODE_CONTROL_TWO || widx == `VAP_IDX_NOLOAD_MODE
                             || widx == `VAP_IDX_ACCUMULATION_MODE || widx == `VAP_IDX_IRQ_EN
                             || widx == `VAP_IDX_IRQ_ST || widx == `VAP_IDX_VRMS_OS
                             || widx == `VAP_IDX_PGAIN || widx == `VAP_IDX_POFFS))
                            ? `VAP_RESP_OKAY : `VAP_RESP_SLVERR;
            if (w_map)
            begin
               case (widx)
                  `VAP_IDX_MODE_CONTROL_TWO:   mode_control_two_q   <= ws[0] ? wd[7:0] : mode_control_two_q;
                  `VAP_IDX_NOLOAD_MODE:  noload_mode_q  <= ws[0] ? wd[7:0] : noload_mode_q;
                  `VAP_IDX_ACCUMULATION_MODE: accumulation_mode_q <= ws[0] ? wd[7:0] : accumulation_mode_q;
                  `VAP_IDX_IRQ_EN:  irq_en_q  <= ws[0] ? wd[7:0] : irq_en_q;
                  // RQ5 offset register
                  `VAP_IDX_VRMS_OS: vrms_os_q <= m_os[11:0];
                  `VAP_IDX_PGAIN:   pgain_q   <= m_gain[11:0];
                  `VAP_IDX_POFFS:   poffs_q   <= m_poff[15:0];
                  default:          mode_control_two_q   <= mode_control_two_q;
               endcase
            end
         end
         else
         begin
            if (aw_hs)
               aw_got_q <= 1'b1;
            if (w_hs)
               w_got_q <= 1'b1;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_ok ? rd_val : 32'h0;
            s_axi_rresp   <= rd_ok ? `VAP_RESP_OKAY : `VAP_RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
         // new events win over a same-cycle write-one clear
         irq_st_q[`VAP_IRQ_SIGN]   <= (irq_st_q[`VAP_IRQ_SIGN] && !st_clr[`VAP_IRQ_SIGN])
                                      || sign_set_q;
         irq_st_q[`VAP_IRQ_NOLOAD] <= (irq_st_q[`VAP_IRQ_NOLOAD] && !st_clr[`VAP_IRQ_NOLOAD])
                                      || nl_set_q;
         // RQ11 RQ13 level interrupt until cleared
         irq_q <= |(irq_st_q & irq_en_q);
      end
   end

endmodule // vap_dsp

// ### verification/vap_dsp_assertions.sv
// Purpose: port checks on vap_dsp: update cadence, register bus timing
// Assumes: one clock, asynchronous active-high reset
// Notes:   bound to every vap_dsp instance
`timescale 1ns/1ps
module vap_chk
(
   input wire               clk,
   input wire               reset,
   input wire               s_axi_awvalid,
   input wire               s_axi_awready,
   input wire               s_axi_wvalid,
   input wire               s_axi_wready,
   input wire [1:0]         s_axi_bresp,
   input wire               s_axi_bvalid,
   input wire               s_axi_bready,
   input wire               s_axi_arvalid,
   input wire               s_axi_arready,
   input wire [31:0]        s_axi_rdata,
   input wire [1:0]         s_axi_rresp,
   input wire               s_axi_rvalid,
   input wire               s_axi_rready,
   input wire signed [31:0] active_power_q,
   input wire               update_tick_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   a_tick_period:
   assert property (update_tick_q |=> !update_tick_q [*4] ##1 update_tick_q)
      else $error("update tick not every fifth clock");
   // power may only move in the few cycles after an update tick
   a_power_hold:
   assert property (!($past(update_tick_q) || $past(update_tick_q, 2)
      || $past(update_tick_q, 3)) |-> $stable(active_power_q))
      else $error("active power moved between updates");
   a_write_answer:
   assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid)
      else $error("write response late");
   a_read_answer:
   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response late");
   a_b_release:
   assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   a_write_block:
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_r_release:
   assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read channel not freed");
   a_refuse_zero:
   assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
      else $error("refused read returned data");
   c_bad_read: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   c_bad_write: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_neg_power: cover property (update_tick_q && active_power_q[31]);
endmodule // vap_chk
bind vap_dsp vap_chk i_vap_chk (.clk(clk), .reset(reset),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .active_power_q(active_power_q),
   .update_tick_q(update_tick_q));

// ### verification/vap_cpu_model.sv
// Purpose: microcontroller side issuing axi4-lite register cycles
// Assumes: one write and one read at most, byte address = 4 * index
// Notes:   tmo rises if the slave never answers
`timescale 1ns/1ps
module vap_cpu_model
(
   input  wire        clk,
   output reg         tmo,
   output reg  [11:0] awaddr,
   output reg         awvalid,
   input  wire        awready,
   output reg  [31:0] wdata,
   output reg  [3:0]  wstrb,
   output reg         wvalid,
   input  wire        wready,
   input  wire [1:0]  bresp,
   input  wire        bvalid,
   output reg         bready,
   output reg  [11:0] araddr,
   output reg         arvalid,
   input  wire        arready,
   input  wire [31:0] rdata,
   input  wire [1:0]  rresp,
   input  wire        rvalid,
   output reg         rready
);
   initial
   begin
      {tmo, awaddr, awvalid, wdata, wstrb, wvalid, bready} = 'h0;
      {araddr, arvalid, rready} = 'h0;
   end
   // ready is up with the request, so it is taken at its first edge and answered at the next
   task wr(input [7:0] ix, input [31:0] d, output [1:0] r);
      integer n;
      begin
         @(posedge clk);
         awaddr <= {2'h0, ix, 2'h0};
         wdata <= d;
         wstrb <= 4'hF;
         {awvalid, wvalid, bready} <= 3'h7;
         for (n = 0; n < 200 && !bvalid; n = n + 1)
         begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
         end
         r = bresp;
         bready <= 1'b0;
         if (!bvalid) tmo <= 1'b1;
      end
   endtask
   task rd(input [7:0] ix, output [31:0] d, output [1:0] r);
      integer n;
      begin
         @(posedge clk);
         araddr <= {2'h0, ix, 2'h0};
         {arvalid, rready} <= 2'h3;
         for (n = 0; n < 200 && !rvalid; n = n + 1)
         begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
         end
         d = rdata;
         r = rresp;
         rready <= 1'b0;
         if (!rvalid) tmo <= 1'b1;
      end
   endtask
endmodule // vap_cpu_model

// ### verification/vap_dsp_tb_top.sv
// Purpose: self-checking bench for vap_dsp
// Assumes: short lowpass shifts so filters settle in a few hundred clocks
// Notes:   analog levels are compared with a small tolerance
`timescale 1ns/1ps
module vap_dsp_tb_top;
   localparam [63:0] RIX = 64'h0C0E0FD9DC414243;
   reg               clk;
   reg               reset;
   reg signed [23:0] v_s, i_s;
   reg [31:0]        seed, frz, rd_d;
   reg [1:0]         rsp;
   reg               e;
   wire [11:0]       awaddr, araddr;
   wire [31:0]       wdata, rdata, ap;
   wire [3:0]        wstrb;
   wire [1:0]        bresp, rresp;
   wire              awvalid, awready, wvalid, wready, bvalid, bready, tick, gate;
   wire              arvalid, arready, rvalid, rready, tmo, irq;
   integer           n_errors, n_checks, k, vv, ii, g;
   longint           pr;
   vap_dsp #(.RMS_SHIFT(4), .PWR_SHIFT(2)) i_vap_dsp (.clk(clk), .reset(reset),
      .v_sample(v_s), .i_sample(i_s), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .active_power_q(ap), .update_tick_q(tick), .noload_gate_q(gate), .irq_q(irq));
   vap_cpu_model i_vap_cpu_model (.clk(clk), .tmo(tmo), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   task test_done;
      begin
         $display("checks %0d errors %0d", n_checks, n_errors);
         if (n_errors == 0 && n_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task chk(input [33:0] gv, input [33:0] xv, input [63:0] m);
      begin
         n_checks = n_checks + 1;
         if (gv !== xv)
         begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %0t %0s got %h exp %h", $time, m, gv, xv);
         end
      end
   endtask
   // analog results carry filter ripple and rounding, so allow 1/64 plus a few lsb
   task near(input [31:0] gv, input integer xv, input [63:0] m);
      integer t;
      begin
         t = (xv < 0 ? -xv : xv) / 64 + 4;
         n_checks = n_checks + 1;
         if ($isunknown(gv) || $signed(gv) - xv > t || xv - $signed(gv) > t)
         begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %0t %0s got %0d exp %0d", $time, m, $signed(gv), xv);
         end
      end
   endtask
   task rdc(input [7:0] ix, input [31:0] xv, input [63:0] m);
      begin
         i_vap_cpu_model.rd(ix, rd_d, rsp);
         chk({rsp, rd_d}, {2'h0, xv}, m);
      end
   endtask
   task wrc(input [7:0] ix, input [31:0] d);
      begin
         i_vap_cpu_model.wr(ix, d, rsp);
         chk({32'h0, rsp}, 34'h0, "wresp");
      end
   endtask
   task setvi(input integer v, input integer i);
      begin
         @(posedge clk);
         v_s <= v[23:0];
         i_s <= i[23:0];
         repeat (800) @(posedge clk);
      end
   endtask
   always @(posedge tmo)
   begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %0t bus timeout", $time);
      test_done;
   end
   initial
   begin
      {n_errors, n_checks} = 0;
      seed = 32'h63DC027F;
      {reset, v_s, i_s} = {1'b1, 48'h0};
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      for (k = 0; k < 8; k = k + 1)
         rdc(RIX[63-8*k -: 8], 32'h0, "rstval");
      i_vap_cpu_model.rd(8'h3F, rd_d, rsp);
      chk({rsp, rd_d}, {2'h2, 32'h0}, "unmap");
      i_vap_cpu_model.wr(8'h40, 32'h1, rsp);
      chk({32'h0, rsp}, 34'h2, "rowrite");
      $display("test registers done");
      wrc(8'h41, 32'hFFFFF010);
      rdc(8'h41, 32'h010, "oswidth");
      repeat (50) @(posedge clk);
      rdc(8'h40, 32'h400, "osadd");
      wrc(8'h41, 32'h800);
      repeat (50) @(posedge clk);
      rdc(8'h40, 32'h0, "osclamp");
      wrc(8'h41, 32'h0);
      $display("test rms offset done");
      wrc(8'h43, 32'h100);
      repeat (50) @(posedge clk);
      chk({2'h0, ap}, 34'h1, "poffs");
      wrc(8'hDC, 32'hFF);
      wrc(8'hD9, 32'h1);
      for (k = 0; k < 3; k = k + 1)
      begin
         wrc(8'h0F, k ? 32'h8 : 32'h0);
         wrc(8'h43, k == 1 ? 32'h100 : 32'hFF00);
         repeat (50) @(posedge clk);
         e = k < 2;
         chk({2'h0, ap}, k == 1 ? 34'h1 : 34'hFFFFFFFF, "psign");
         rdc(8'hDC, {31'h0, e}, "sflag");
         chk({33'h0, irq}, {33'h0, e}, "sirq");
         wrc(8'hDC, 32'hFF);
         repeat (5) @(posedge clk);
         chk({33'h0, irq}, 34'h0, "sclr");
      end
      wrc(8'h43, 32'h0);
      wrc(8'hD9, 32'h0);
      $display("test sign done");
      seed = xs(seed);
      vv = seed[21:0] | 22'h1000;
      setvi(seed[31] ? -vv : vv, 0);
      // freeze first: the rms filter still creeps by a few lsb per update
      wrc(8'h0C, 32'h1);
      i_vap_cpu_model.rd(8'h40, frz, rsp);
      near(frz, vv, "rms");
      setvi(seed[31] ? -vv / 2 : vv / 2, 0);
      rdc(8'h40, frz, "frozen");
      wrc(8'h0C, 32'h0);
      repeat (800) @(posedge clk);
      i_vap_cpu_model.rd(8'h40, rd_d, rsp);
      near(rd_d, vv / 2, "rmsupd");
      $display("test rms done");
      for (k = 0; k < 3; k = k + 1)
      begin
         g = k == 0 ? 0 : (k == 1 ? 2047 : -2048);
         wrc(8'h42, g & 32'hFFF);
         seed = xs(seed);
         vv = seed[20:0];
         seed = xs(seed);
         ii = seed[31] ? -seed[20:0] : seed[20:0];
         setvi(vv, ii);
         pr = vv;
         pr = (pr * ii) >>> 22;
         near(ap, int'(pr + pr * g / 4096), "gain");
      end
      wrc(8'h42, 32'h0);
      $display("test gain done");
      setvi(32'h28000, 32'h800);
      wrc(8'hDC, 32'hFF);
      for (k = 0; k < 4; k = k + 1)
      begin
         wrc(8'h0E, k);
         repeat (50) @(posedge clk);
         chk({33'h0, gate}, {33'h0, k == 1}, "nlgate");
      end
      rdc(8'hDC, 32'h2, "nlflag");
      wrc(8'hD9, 32'h2);
      repeat (5) @(posedge clk);
      chk({33'h0, irq}, 34'h1, "nlirq");
      wrc(8'hDC, 32'h2);
      repeat (5) @(posedge clk);
      chk({33'h0, irq}, 34'h0, "nlclr");
      $display("test noload done");
      test_done;
   end
endmodule // vap_dsp_tb_top
